// ---- bench/lagps_port_model.sv ----
module lagps_port_model (
  // Clock
  input wire logic core_clk,
  // Bench controls
  input wire logic [23:0] link_want,
  input wire logic slow,
  // Far side of the selector
  output logic out_ready = 1'b0,
  output logic [lagps_pkg::NUM_PORTS-1:0] link_up_pin = '0
);
  timeunit 1ns;
  timeprecision 100ps;
  import lagps_pkg::*;
  logic [7:0] lfsr_q = 8'hA5;
  // Links rise only as the bench allows, after it has set up the groups
  always_ff @(posedge core_clk)
  begin
    lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    link_up_pin <= link_want;
    out_ready <= !slow || lfsr_q[1:0] == 2'h0; // Slow sink stalls three of four
  end
endmodule

// ---- bench/lagps_properties.sv ----
module lagps_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Descriptor stream
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [lagps_pkg::LPORT_W-1:0] in_lport,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [lagps_pkg::PORT_W-1:0] out_port,
  input wire logic out_drop
);
  timeunit 1ns;
  timeprecision 100ps;
  import lagps_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Handshake steps
  sequence s_take; in_valid && in_ready; endsequence
  sequence s_stall; out_valid && !out_ready; endsequence
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  // A held result must not move, or frames of a flow could part ways
  property p_hold; s_stall |=> out_valid && $stable(out_port) && $stable(out_drop); endproperty
  a_hold: assert property (p_hold) else $error("result changed under stall");
  property p_stall; s_stall |-> !in_ready; endproperty
  a_stall: assert property (p_stall) else $error("descriptor taken under stall");
  property p_take; s_take |=> out_valid; endproperty
  a_take: assert property (p_take) else $error("no result after descriptor");
  property p_phys;
    s_take ##0 (in_lport < 6'h18) |=> !out_drop && {1'b0, out_port} == $past(in_lport);
  endproperty
  a_phys: assert property (p_phys) else $error("plain port not passed through");
  property p_bad; s_take ##0 (in_lport > 6'h1C) |=> out_drop; endproperty
  a_bad: assert property (p_bad) else $error("invalid logical port not dropped");
  property p_wr; s_wr |-> ##[1:3] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer missing");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved early");
endmodule

bind lagps_selector lagps_properties u_prop (
  .core_clk(core_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .in_valid(in_valid),
  .in_ready(in_ready), .in_lport(in_lport), .out_valid(out_valid), .out_ready(out_ready),
  .out_port(out_port), .out_drop(out_drop)
);

// ---- bench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lagps_pkg::*;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
  // Bench drive and design outputs
  logic core_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, ips = '0, ipd = '0, seed = 32'h9D6EB318;
  logic awready, wready, bvalid, arready, rvalid, in_ready, out_valid, out_ready, out_drop;
  logic [1:0] bresp, rresp;
  logic [4:0] out_port;
  logic [23:0] link_pin, link = '0;
  logic in_valid = 1'b0, v4 = 1'b0, l4 = 1'b0;
  logic [5:0] lport = '0;
  logic [47:0] smac = '0, dmac = '0;
  logic [15:0] l4s = '0, l4d = '0;
  // Bench copy of the configuration
  logic [23:0] mem [5] = '{default: '0};
  logic [1:0] md [5] = '{default: '0};
  logic [3:0] hen = 4'hD;
  int error_cnt = 0, checks_done = 0;

  always #12.5 core_clk = ~core_clk;

  lagps_selector uut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_up_pin(link_pin), .in_valid(in_valid), .in_ready(in_ready), .in_lport(lport),
    .in_smac(smac), .in_dmac(dmac), .in_is_ipv4(v4), .in_ip_src(ips), .in_ip_dst(ipd),
    .in_is_l4(l4), .in_l4_src(l4s), .in_l4_dst(l4d), .out_valid(out_valid),
    .out_ready(out_ready), .out_port(out_port), .out_drop(out_drop));

  lagps_port_model u_far (.core_clk(core_clk), .link_want(link), .slow(slow),
    .out_ready(out_ready), .link_up_pin(link_pin));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] fx(logic [47:0] x);
    return x[15:0] ^ x[31:16] ^ x[47:32];
  endfunction
  function automatic logic [15:0] sw(logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction
  // First ten linked members by port number serve, the rest wait
  function automatic logic [23:0] act(int g);
    logic [23:0] a;
    int n;
    a = '0;
    n = 0;
    for (int p = 0; p < NUM_PORTS; p++)
      if (mem[g][p] && link[p] && n < MAX_MEMBERS)
      begin
        a[p] = 1'b1;
        n++;
      end
    return a;
  endfunction
  // Expected {drop, port} for the descriptor now on the inputs
  function automatic logic [5:0] exp_sel();
    logic [23:0] a;
    logic [15:0] m;
    int k;
    if (lport < 24) return {1'b0, lport[4:0]};
    if (lport > 28 || md[lport - 24] == 2'h0) return 6'h20;
    a = act(lport - 24);
    if (a == '0) return 6'h20;
    m = (hen[0] ? fx(smac) : 16'h0) ^ (hen[1] ? sw(fx(dmac)) : 16'h0);
    if (hen[2] && v4) m ^= ips[15:0] ^ ips[31:16] ^ sw(ipd[15:0] ^ ipd[31:16]);
    if (hen[3] && v4 && l4) m ^= l4s ^ sw(l4d);
    m ^= {m[10:0], m[15:11]};
    k = m % $countones(a);
    for (int p = 0; p < NUM_PORTS; p++)
      if (a[p])
      begin
        if (k == 0) return {1'b0, 5'(p)};
        k--;
      end
    return 6'h3F;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge core_clk);
      // Release each channel by NBA so the design still sees it at this edge
      if (!ad && awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready === 1'b1)
      begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                    input string n);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(n, e, rdata)
    `CHK("rresp", er, rresp)
  endtask
  // Writing a group takes its ports away from every other group
  task automatic cfg(int g, logic [23:0] m, logic [1:0] mo);
    for (int h = 0; h < NUM_GROUPS; h++) if (h != g) mem[h] &= ~m;
    mem[g] = m;
    md[g] = mo;
    wr(MEMB_BASE_OFS + 8'(4 * g), {8'h0, m}, RESP_OKAY);
    wr(MODE_BASE_OFS + 8'(4 * g), {30'h0, mo}, RESP_OKAY);
  endtask
  // Random flows, some repeated, with the global enables reshuffled now and then
  task automatic traffic(int n);
    logic [31:0] r;
    logic [5:0] e;
    repeat (n)
    begin
      r = xs();
      if (r[2:0] == 3'h0)
      begin
        hen = r[31:28];
        wr(HASH_CTRL_OFS, {28'h0, hen}, RESP_OKAY);
      end
      if (r[9:8] != 2'h0) {smac, dmac, ips, ipd} <= {xs(), xs(), xs(), xs(), xs()};
      {l4s, l4d, v4, l4} <= {xs(), r[3], r[5]};
      lport <= r[6] ? 6'(24 + r[7]) : r[15:10];
      in_valid <= 1'b1;
      do @(posedge core_clk); while (in_ready !== 1'b1);
      e = exp_sel();
      in_valid <= 1'b0;
      do @(posedge core_clk); while ((out_valid && out_ready) !== 1'b1);
      `CHK("drop", e[5], out_drop)
      if (!e[5]) `CHK("port", e[4:0], out_port)
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog, far beyond the several hundred cycles the tests need
  initial
  begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    results();
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(HASH_CTRL_OFS, 32'hD, RESP_OKAY, "hash_ctrl");
    rd(MODE_BASE_OFS + 8'h10, 32'h0, RESP_OKAY, "mode");
    rd(MEMB_BASE_OFS + 8'h08, 32'h0, RESP_OKAY, "members");
    rd(8'hFC, 32'h0, RESP_SLVERR, "unmapped");
    wr(LINK_STAT_OFS, 32'hF, RESP_SLVERR);
    $display("test reset done");
    cfg(0, 24'h000FFF, 2'h1);
    cfg(1, 24'h00F000, 2'h2);
    // Cables go in only once the groups are set up at both ends
    link <= 24'hFFFFFF;
    repeat (4) @(posedge core_clk);
    rd(ACT_BASE_OFS, {8'h0, act(0)}, RESP_OKAY, "active");
    rd(STBY_BASE_OFS, {8'h0, mem[0] & link & ~act(0)}, RESP_OKAY, "standby");
    traffic(60);
    $display("test hash done");
    link <= 24'hFFDFF7;
    slow <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(ACT_BASE_OFS, {8'h0, act(0)}, RESP_OKAY, "active_after_loss");
    traffic(40);
    $display("test link loss done");
    cfg(1, mem[1] | 24'h000020, 2'h3);
    rd(MEMB_BASE_OFS, {8'h0, mem[0]}, RESP_OKAY, "members_moved");
    for (int m = 0; m < 4; m++)
    begin
      cfg(0, mem[0], 2'(m));
      traffic(8);
    end
    $display("test modes done");
    results();
  end
endmodule

// ---- rtl/lagps_hash.sv ----
module lagps_hash (
  // Header fields in, hash out
  lagps_hash_if.calc hif
);
  import lagps_pkg::*;

  // Fold a 48-bit field to the hash width
  function automatic logic [15:0] fold16(input logic [47:0] v);
    fold16 = v[15:0] ^ v[31:16] ^ v[47:32];
  endfunction

  // Swap halves so equal fields do not cancel
  function automatic logic [15:0] swap8(input logic [15:0] v);
    swap8 = {v[7:0], v[15:8]};
  endfunction

  logic [15:0] smac_w;
  logic [15:0] dmac_w;
  logic [15:0] ip_w;
  logic [15:0] l4_w;
  logic [15:0] mix_w;

  // Disabled contributors add nothing at all
  assign smac_w = hif.en[HASH_SMAC_BIT] ? fold16(hif.smac) : 16'h0000;
  assign dmac_w = hif.en[HASH_DMAC_BIT] ? swap8(fold16(hif.dmac)) : 16'h0000;
  assign ip_w = (hif.en[HASH_IP_BIT] && hif.is_ipv4) ?
                (hif.ip_src[15:0] ^ hif.ip_src[31:16] ^ swap8(hif.ip_dst[15:0] ^
                 hif.ip_dst[31:16])) : 16'h0000;
  assign l4_w = (hif.en[HASH_L4_BIT] && hif.is_ipv4 && hif.is_l4) ?
                (hif.l4_src ^ swap8(hif.l4_dst)) : 16'h0000;

  // Function of the header and the enables only, so one flow hashes alike while the enables stay unchanged
  assign mix_w = smac_w ^ dmac_w ^ ip_w ^ l4_w;
  assign hif.hash = mix_w ^ {mix_w[10:0], mix_w[15:11]};
endmodule

// ---- rtl/lagps_hash_if.sv ----
interface lagps_hash_if;
  import lagps_pkg::*;

  logic [47:0] smac;
  logic [47:0] dmac;
  logic [31:0] ip_src;
  logic [31:0] ip_dst;
  logic [15:0] l4_src;
  logic [15:0] l4_dst;
  logic is_ipv4;
  logic is_l4;
  logic [HASH_EN_W-1:0] en;
  logic [HASH_W-1:0] hash;

  modport req (output smac, dmac, ip_src, ip_dst, l4_src, l4_dst, is_ipv4, is_l4, en,
               input hash);
  modport calc (input smac, dmac, ip_src, ip_dst, l4_src, l4_dst, is_ipv4, is_l4, en,
                output hash);
endinterface

// ---- rtl/lagps_pkg.sv ----
package lagps_pkg;

  // Port and group dimensions
  localparam int NUM_PORTS = 24;
  localparam int NUM_GROUPS = 5;
  localparam int MAX_MEMBERS = 10;
  localparam int PORT_W = 5;
  localparam int LPORT_W = 6;
  localparam int GRP_W = 3;
  localparam int CNT_W = 5;
  localparam int HASH_W = 16;

  // Register map, one aligned word each
  localparam int ADDR_W = 8;
  localparam logic [7:0] HASH_CTRL_OFS = 8'h00;
  localparam logic [7:0] LINK_STAT_OFS = 8'h04;
  localparam logic [7:0] MODE_BASE_OFS = 8'h20;
  localparam logic [7:0] MEMB_BASE_OFS = 8'h40;
  localparam logic [7:0] ACT_BASE_OFS = 8'h60;
  localparam logic [7:0] STBY_BASE_OFS = 8'h80;
  localparam logic [2:0] BANK_GLOBAL = HASH_CTRL_OFS[7:5];
  localparam logic [2:0] BANK_MODE = MODE_BASE_OFS[7:5];
  localparam logic [2:0] BANK_MEMB = MEMB_BASE_OFS[7:5];
  localparam logic [2:0] BANK_ACT = ACT_BASE_OFS[7:5];
  localparam logic [2:0] BANK_STBY = STBY_BASE_OFS[7:5];
  localparam logic [2:0] IDX_HASH = HASH_CTRL_OFS[4:2];
  localparam logic [2:0] IDX_LINK = LINK_STAT_OFS[4:2];

  // Hash contributor enable fields
  localparam int HASH_EN_W = 4;
  localparam int HASH_SMAC_BIT = 0;
  localparam int HASH_DMAC_BIT = 1;
  localparam int HASH_IP_BIT = 2;
  localparam int HASH_L4_BIT = 3;
  localparam logic [3:0] HASH_EN_RST = 4'hD;

  // Group mode field
  localparam int MODE_W = 2;
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_STATIC = 2'h1,
    MODE_LACP_ACTIVE = 2'h2,
    MODE_LACP_PASSIVE = 2'h3
  } lagps_mode_t;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/lagps_selector.sv ----
module lagps_selector (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite register slave
  input wire logic [lagps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lagps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Member link state from the ports
  input wire logic [lagps_pkg::NUM_PORTS-1:0] link_up_pin,
  // Frame descriptors from forwarding
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [lagps_pkg::LPORT_W-1:0] in_lport,
  input wire logic [47:0] in_smac,
  input wire logic [47:0] in_dmac,
  input wire logic in_is_ipv4,
  input wire logic [31:0] in_ip_src,
  input wire logic [31:0] in_ip_dst,
  input wire logic in_is_l4,
  input wire logic [15:0] in_l4_src,
  input wire logic [15:0] in_l4_dst,
  // Chosen egress port
  output logic out_valid,
  input wire logic out_ready,
  output logic [lagps_pkg::PORT_W-1:0] out_port,
  output logic out_drop
);
  import lagps_pkg::*;

  logic [NUM_PORTS-1:0] link_s1_q;
  logic [NUM_PORTS-1:0] link_up_q;
  logic [HASH_EN_W-1:0] hash_en_q;
  lagps_mode_t mode_q [NUM_GROUPS];
  logic [NUM_PORTS-1:0] memb_q [NUM_GROUPS];
  logic [NUM_PORTS-1:0] live_w [NUM_GROUPS];
  logic [NUM_PORTS-1:0] active_w [NUM_GROUPS];
  logic [NUM_PORTS-1:0] stby_w [NUM_GROUPS];
  logic [CNT_W-1:0] cnt_w [NUM_GROUPS];

  // Keep the first MAX_MEMBERS live members, in port order
  function automatic logic [NUM_PORTS-1:0] first_n(input logic [NUM_PORTS-1:0] m);
    logic [CNT_W-1:0] n;
    first_n = '0;
    n = '0;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (m[i] && n < CNT_W'(MAX_MEMBERS))
      begin
        first_n[i] = 1'b1;
        n = n + 1'b1;
      end
    end
  endfunction

  // Count set bits of an active map
  function automatic logic [CNT_W-1:0] popcount(input logic [NUM_PORTS-1:0] m);
    popcount = '0;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      popcount = popcount + CNT_W'(m[i]);
    end
  endfunction

  // Port number of the idx-th set bit
  function automatic logic [PORT_W-1:0] nth_port(input logic [NUM_PORTS-1:0] m,
                                                 input logic [CNT_W-1:0] idx);
    logic [CNT_W-1:0] k;
    nth_port = '0;
    k = '0;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (m[i])
      begin
        if (k == idx)
          nth_port = PORT_W'(i);
        k = k + 1'b1;
      end
    end
  endfunction

  // Byte-lane merge of a write into the old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++)
    begin
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // Mapped address check, shared by read and write paths
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic wr);
    logic [2:0] bank;
    logic [2:0] idx;
    bank = a[7:5];
    idx = a[4:2];
    addr_hit = 1'b0;
    if (a[1:0] == 2'h0)
    begin
      if (bank == BANK_GLOBAL)
        addr_hit = (idx == IDX_HASH) || (!wr && idx == IDX_LINK);
      else if (idx < GRP_W'(NUM_GROUPS))
        addr_hit = (bank == BANK_MODE) || (bank == BANK_MEMB) ||
                   (!wr && (bank == BANK_ACT || bank == BANK_STBY));
    end
  endfunction

  // Register contents at an address, for reads and write merging
  function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
    logic [GRP_W-1:0] gi;
    gi = (a[4:2] < GRP_W'(NUM_GROUPS)) ? a[4:2] : '0;
    reg_word = '0;
    case (a[7:5])
      BANK_GLOBAL: reg_word = (a[4:2] == IDX_HASH) ? 32'(hash_en_q) : 32'(link_up_q);
      BANK_MODE: reg_word = 32'(mode_q[gi]);
      BANK_MEMB: reg_word = 32'(memb_q[gi]);
      BANK_ACT: reg_word = 32'(active_w[gi]);
      BANK_STBY: reg_word = 32'(stby_w[gi]);
      default: reg_word = '0;
    endcase
  endfunction

  // Link pins are asynchronous to the core clock
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      link_s1_q <= '0;
      link_up_q <= '0;
    end
    else
    begin
      link_s1_q <= link_up_pin;
      link_up_q <= link_s1_q;
    end
  end

  // Active and standby maps per group, live from link state
  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : g_grp
    assign live_w[g] = (mode_q[g] != MODE_DISABLED) ? (memb_q[g] & link_up_q) : '0;
    assign active_w[g] = first_n(live_w[g]);
    assign stby_w[g] = live_w[g] & ~active_w[g];
    assign cnt_w[g] = popcount(active_w[g]);
  end

  // AXI write path
  logic aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic b_valid_q;
  logic [1:0] b_resp_q;
  logic wr_fire;
  logic wr_ok;
  logic [2:0] wr_bank;
  logic [GRP_W-1:0] wr_idx;
  logic [31:0] wr_word;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_bvalid = b_valid_q;
  assign s_axi_bresp = b_resp_q;
  assign wr_fire = aw_full_q && w_full_q && !b_valid_q;
  assign wr_ok = addr_hit(aw_addr_q, 1'b1);
  assign wr_bank = aw_addr_q[7:5];
  assign wr_idx = aw_addr_q[4:2];
  assign wr_word = merge(reg_word(aw_addr_q), w_data_q, w_strb_q);

  // Address and data are held until both have arrived
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      b_valid_q <= 1'b0;
      b_resp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_full_q <= 1'b0;
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_full_q <= 1'b0;
      if (wr_fire)
      begin
        b_valid_q <= 1'b1;
        b_resp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        b_valid_q <= 1'b0;
    end
  end

  // Configuration registers; hash enables are global, not per group
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      hash_en_q <= HASH_EN_RST;
      for (int g = 0; g < NUM_GROUPS; g++)
      begin
        mode_q[g] <= MODE_DISABLED;
        memb_q[g] <= '0;
      end
    end
    else if (wr_fire && wr_ok)
    begin
      if (wr_bank == BANK_GLOBAL)
        hash_en_q <= wr_word[HASH_EN_W-1:0];
      for (int g = 0; g < NUM_GROUPS; g++)
      begin
        if (wr_bank == BANK_MODE && wr_idx == GRP_W'(g))
          mode_q[g] <= lagps_mode_t'(wr_word[MODE_W-1:0]);
        // Joining one group removes the port from every other group
        if (wr_bank == BANK_MEMB)
          memb_q[g] <= (wr_idx == GRP_W'(g)) ? wr_word[NUM_PORTS-1:0] :
                       (memb_q[g] & ~wr_word[NUM_PORTS-1:0]);
      end
    end
  end

  // AXI read path, one read in flight
  logic r_valid_q;
  logic [31:0] r_data_q;
  logic [1:0] r_resp_q;
  logic rd_ok;

  assign s_axi_arready = !r_valid_q;
  assign s_axi_rvalid = r_valid_q;
  assign s_axi_rdata = r_data_q;
  assign s_axi_rresp = r_resp_q;
  assign rd_ok = addr_hit(s_axi_araddr, 1'b0);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      r_valid_q <= 1'b0;
      r_data_q <= '0;
      r_resp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !r_valid_q)
    begin
      r_valid_q <= 1'b1;
      r_data_q <= rd_ok ? reg_word(s_axi_araddr) : 32'h0000_0000;
      r_resp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      r_valid_q <= 1'b0;
  end

  // Hash of the offered descriptor
  lagps_hash_if hif();

  assign hif.smac = in_smac;
  assign hif.dmac = in_dmac;
  assign hif.ip_src = in_ip_src;
  assign hif.ip_dst = in_ip_dst;
  assign hif.l4_src = in_l4_src;
  assign hif.l4_dst = in_l4_dst;
  assign hif.is_ipv4 = in_is_ipv4;
  assign hif.is_l4 = in_is_l4;
  assign hif.en = hash_en_q;

  lagps_hash u_hash (
    .hif(hif.calc)
  );

  // Logical port decode: groups follow the physical ports
  logic in_is_grp;
  logic [GRP_W-1:0] sel_grp;
  logic [CNT_W-1:0] sel_cnt;
  logic [CNT_W-1:0] div_w;
  logic [CNT_W-1:0] member_idx;
  logic grp_ok;
  logic [PORT_W-1:0] next_port;
  logic next_drop;
  logic accept;

  assign in_is_grp = (in_lport >= LPORT_W'(NUM_PORTS)) &&
                     (in_lport < LPORT_W'(NUM_PORTS + NUM_GROUPS));
  assign sel_grp = in_is_grp ? GRP_W'(in_lport - LPORT_W'(NUM_PORTS)) : '0;
  assign sel_cnt = cnt_w[sel_grp];
  // Divisor forced to one when empty; that case drops anyway
  assign div_w = (sel_cnt == '0) ? CNT_W'(1) : sel_cnt;
  assign member_idx = CNT_W'(hif.hash % HASH_W'(div_w));
  assign grp_ok = (mode_q[sel_grp] != MODE_DISABLED) && (sel_cnt != '0);
  assign next_port = in_is_grp ? nth_port(active_w[sel_grp], member_idx) :
                     PORT_W'(in_lport);
  assign next_drop = in_is_grp ? !grp_ok : (in_lport >= LPORT_W'(NUM_PORTS));

  // One output stage; selection uses link state at acceptance
  logic out_valid_q;
  logic [PORT_W-1:0] out_port_q;
  logic out_drop_q;

  assign in_ready = !out_valid_q || out_ready;
  assign accept = in_valid && in_ready;
  assign out_valid = out_valid_q;
  assign out_port = out_port_q;
  assign out_drop = out_drop_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      out_valid_q <= 1'b0;
      out_port_q <= '0;
      out_drop_q <= 1'b0;
    end
    else
    begin
      if (in_ready)
        out_valid_q <= in_valid;
      if (accept)
      begin
        out_port_q <= next_port;
        out_drop_q <= next_drop;
      end
    end
  end
endmodule
